// >>> shared/dmr_pkg.sv
// package with constants and types for the dram mode register block
//------------------------------------------------------------------
// How it works
// [RQ1] all four strobes low captures address and bank
// [RQ2] controller raises clock enable, waits write interval
// [RQ3] rewrites allowed only with all banks idle
// [RQ4] no reset value; controller writes before use
// [RQ5] fixed field decode of address bits
// [RQ6] bursts wrap inside burst-length column block
// [RQ7] length four: order 0-1-2-3, low bits zero
// [RQ8] length eight: start 0 or 4, wraps
// [RQ9] one burst length for reads and writes
// [RQ10] sequential ordering only, via burst type bit
// [RQ11] read data at edge n plus read latency
// [RQ12] write data at edge n plus write latency
// [RQ13] write latency 1-3 keeps receivers on
// [RQ14] controller avoids reserved field codes
// [RQ15] bit 7 high enters hidden test mode
// [RQ16] dll reset bit self-clears when done
// [RQ17] no power-down within ten clocks of reset
// [RQ18] frequency change: disable, change, enable, wait
// [RQ19] recalibrate on refresh and idle nops
// [RQ20] allow 20 us before impedance is optimal
// [RQ21] bank bits zero select main register
// [RQ22] decoded latencies held in registers
//------------------------------------------------------------------
package dmr_pkg;
    // address field positions
    localparam int BL_LSB      = 0;
    localparam int BT_BIT      = 3;   // burst_type_bit
    localparam int RL_HI_BIT   = 2;
    localparam int RL_LO_LSB   = 4;
    localparam int TM_BIT      = 7;
    localparam int DLL_BIT     = 8;
    localparam int WL_LSB      = 9;
    // burst length codes
    localparam logic [1:0] BL_CODE_4 = 2'h2;
    localparam logic [1:0] BL_CODE_8 = 2'h3;
    // latency limits
    localparam logic [3:0] RL_MIN    = 4'h4;
    localparam logic [3:0] RL_MAX    = 4'hB;
    localparam logic [2:0] WL_RX_MAX = 3'h3;
    // dll reset duration, parameter default cycles
    localparam int DLL_RST_CYCLES = 16;
    // power-down guard after dll reset
    localparam logic [3:0] PD_GUARD = 4'hA;
    // 20 us calibration settle at 100 ns per clock
    localparam int CAL_SETTLE_NS     = 20000;
    localparam int CLK_PERIOD_NS     = 100;
    localparam int CAL_SETTLE_CYCLES = (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one command bus sample
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [11:0] addr;
        logic [2:0]  bank;
    } dmr_cmd_s;

    // decoded mode fields
    typedef struct packed {
        logic       burst8;
        logic       sequential;
        logic [3:0] read_latency;
        logic [2:0] write_latency;
        logic       test_mode;
        logic       dll_reset;
    } dmr_mode_s;
endpackage : dmr_pkg

// >>> rtl/dmr_delay.sv
// programmable delay line: pulse out after 1..15 cycles
`timescale 1ns/1ns
`default_nettype none
module dmr_delay
    import dmr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic [3:0] lat,
    output logic            fire
);
    //------------------------------------------------------------------
    // shift line
    //------------------------------------------------------------------
    logic [15:0] line;   // bit k set k cycles after start

    // shift every cycle; overlapping commands each keep their own bit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            line <= 16'h0000;
        end else begin
            line <= {line[14:0], start};
        end
    end

    // fire is registered from bit lat-2 (from start when lat is 1), so it is sampled high at edge n+lat
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fire <= 1'b0;
        end else begin
            fire <= (lat == 4'h1) ? start : ((lat == 4'h0) ? 1'b0 : line[lat - 4'h2]);
        end
    end
endmodule : dmr_delay
`default_nettype wire

// >>> rtl/dmr_burst_seq.sv
// burst column sequencer: wraps inside the burst block
`timescale 1ns/1ns
`default_nettype none
module dmr_burst_seq
    import dmr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic       burst8,
    input  wire logic [7:0] col,
    output logic [7:0]      col_out,
    output logic            active
);
    //------------------------------------------------------------------
    // burst counter
    //------------------------------------------------------------------
    logic [7:0] base;    // block address plus start
    logic [2:0] step;    // beats issued
    // step value one past the last beat; length eight wraps to zero
    wire  [2:0] stop  = burst8 ? 3'h0 : 3'h4;
    wire  [2:0] off   = base[2:0] + step;
    // wrap inside the block by keeping only the low bits
    wire  [7:0] next_col = burst8 ? {base[7:3], off} : {base[7:2], off[1:0]}; // [RQ6] [RQ8]

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            base    <= 8'h00;
            step    <= 3'h0;
            active  <= 1'b0;
            col_out <= 8'h00;
        end else if (start) begin
            // low two column bits forced zero; bit 2 is the length-eight start [RQ7] [RQ8]
            base    <= {col[7:2], 2'h0};
            step    <= 3'h1;
            active  <= 1'b1;
            col_out <= {col[7:2], 2'h0};
        end else if (active) begin
            // drop one cycle after the last beat so every beat is shown
            if (step == stop) begin
                active  <= 1'b0;
            end else begin
                col_out <= next_col;
                step    <= step + 3'h1;
            end
        end
    end
endmodule : dmr_burst_seq
`default_nettype wire

// >>> rtl/dmr_mode_reg.sv
// mode register: command decode, fields, dll reset, latency timing
`timescale 1ns/1ns
`default_nettype none
module dmr_mode_reg
    import dmr_pkg::*;
#(
    parameter int DLL_CYCLES = DLL_RST_CYCLES
)
(
    input  wire logic      sys_clk,
    input  wire logic      reset,
    input  wire logic      cke,
    input  wire dmr_cmd_s  cmd,
    input  wire logic      read_cmd,
    input  wire logic      write_cmd,
    input  wire logic      refresh_cmd,
    input  wire logic [7:0] col_addr,
    output dmr_mode_s      mode,
    output logic [14:0]    ext_image,
    output logic           read_data_start,
    output logic           write_data_start,
    output logic           rx_enable,
    output logic [7:0]     burst_col,
    output logic           burst_active,
    output logic           calibrate,
    output logic           dll_busy,
    output logic           powerdown_ok,
    output logic           impedance_settled
);
    //------------------------------------------------------------------
    // command decode
    //------------------------------------------------------------------
    wire all_low  = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
    // write needs clock enable high [RQ1] [RQ2]
    wire mrw      = cke & all_low & ~cmd.bank[0] & ~cmd.bank[1]; // [RQ21]
    wire emrw     = cke & all_low & cmd.bank[0];                  // [RQ21]
    wire nop_cmd  = ~cmd.cs_n & cmd.ras_n & cmd.cas_n & cmd.we_n;

    //------------------------------------------------------------------
    // field decode of incoming address
    //------------------------------------------------------------------
    wire [3:0] next_rl = {cmd.addr[RL_HI_BIT], cmd.addr[RL_LO_LSB +: 3]}; // [RQ5] [RQ11]
    wire [2:0] next_wl = cmd.addr[WL_LSB +: 3];                          // [RQ5] [RQ12]

    //------------------------------------------------------------------
    // dll reset timer
    //------------------------------------------------------------------
    logic [7:0] dll_cnt;       // cycles left in dll reset
    logic [3:0] pd_cnt;        // guard against power-down
    wire        dll_done = dll_busy & (dll_cnt == 8'h01);

    //------------------------------------------------------------------
    // mode register: only address fields captured; bank bits just select it
    //------------------------------------------------------------------
    // note no reset value is documented; zero chosen so outputs are defined [RQ4]
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode <= '0;
        end else if (mrw) begin
            mode.burst8        <= (cmd.addr[BL_LSB +: 2] == BL_CODE_8); // [RQ5] [RQ9]
            mode.sequential    <= ~cmd.addr[BT_BIT];                    // [RQ10]
            mode.read_latency  <= next_rl;                              // [RQ22]
            mode.write_latency <= next_wl;                              // [RQ22]
            mode.test_mode     <= cmd.addr[TM_BIT];                     // [RQ15]
            mode.dll_reset     <= cmd.addr[DLL_BIT];                    // [RQ16]
        end else if (dll_done) begin
            mode.dll_reset <= 1'b0;                                     // [RQ16]
        end
    end

    // extended register image is just stored for the neighbour block
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ext_image <= 15'h0000;
        end else if (emrw) begin
            ext_image <= {cmd.bank, cmd.addr};
        end
    end

    // dll reset runs a fixed time, then clears the stored bit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dll_busy <= 1'b0;
            dll_cnt  <= 8'h00;
        end else if (mrw && cmd.addr[DLL_BIT]) begin
            dll_busy <= 1'b1;
            dll_cnt  <= 8'(DLL_CYCLES);
        end else if (dll_busy) begin
            dll_cnt  <= dll_cnt - 8'h01;
            dll_busy <= ~dll_done;
        end
    end

    // power-down guard for ten clocks after a dll reset write
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pd_cnt       <= 4'h0;
            powerdown_ok <= 1'b1;
        end else if (mrw && cmd.addr[DLL_BIT]) begin
            pd_cnt       <= PD_GUARD;                                   // [RQ17]
            powerdown_ok <= 1'b0;
        end else if (pd_cnt != 4'h0) begin
            pd_cnt       <= pd_cnt - 4'h1;
            powerdown_ok <= (pd_cnt == 4'h1);
        end
    end

    //------------------------------------------------------------------
    // latency timing
    //------------------------------------------------------------------
    dmr_delay u_rd_delay (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (read_cmd),
        .lat     (mode.read_latency),
        .fire    (read_data_start)                                      // [RQ11]
    );

    dmr_delay u_wr_delay (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (write_cmd),
        .lat     ({1'b0, mode.write_latency}),
        .fire    (write_data_start)                                     // [RQ12]
    );

    // short write latency keeps receivers on; otherwise on around writes
    logic [3:0] rx_hold;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_hold   <= 4'h0;
            rx_enable <= 1'b0;
        end else begin
            rx_hold   <= write_cmd ? 4'hC : ((rx_hold != 4'h0) ? rx_hold - 4'h1 : 4'h0);
            rx_enable <= (mode.write_latency <= WL_RX_MAX) | write_cmd | (rx_hold != 4'h0); // [RQ13]
        end
    end

    //------------------------------------------------------------------
    // burst column ordering, same length for reads and writes
    //------------------------------------------------------------------
    dmr_burst_seq u_burst (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (read_cmd | write_cmd),                                // [RQ9]
        .burst8  (mode.burst8),
        .col     (col_addr),
        .col_out (burst_col),
        .active  (burst_active)
    );

    //------------------------------------------------------------------
    // impedance calibration
    //------------------------------------------------------------------
    logic [7:0]  rd_busy;      // read in progress window
    logic [15:0] settle_cnt;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_busy   <= 8'h00;
            calibrate <= 1'b0;
        end else begin
            rd_busy   <= read_cmd ? 8'h14 : ((rd_busy != 8'h00) ? rd_busy - 8'h01 : 8'h00);
            calibrate <= refresh_cmd | (nop_cmd & (rd_busy == 8'h00) & ~read_cmd); // [RQ19]
        end
    end

    // settle flag after 20 us of clock
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            settle_cnt        <= 16'h0000;
            impedance_settled <= 1'b0;
        end else if (!impedance_settled) begin
            settle_cnt        <= settle_cnt + 16'h0001;
            impedance_settled <= (settle_cnt == 16'(CAL_SETTLE_CYCLES - 1)); // [RQ20]
        end
    end
endmodule : dmr_mode_reg
`default_nettype wire

// >>> dv/dmr_mode_reg_properties.sv
// checker: decode and timing properties of the mode register
`timescale 1ns/1ns
`default_nettype none
module dmr_mode_reg_chk
    import dmr_pkg::*;
#(
    parameter int DLL_CYCLES = 16
)
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        cke,
    input wire dmr_cmd_s    cmd,
    input wire logic        read_cmd,
    input wire logic        write_cmd,
    input wire dmr_mode_s   mode,
    input wire logic [14:0] ext_image,
    input wire logic        read_data_start,
    input wire logic        write_data_start,
    input wire logic        rx_enable,
    input wire logic        burst_active,
    input wire logic        dll_busy,
    input wire logic        powerdown_ok
);
    localparam int DLL_LIM = DLL_CYCLES + 2;  // slack for the clear edge
    // all four strobes low, with and without bank routing
    wire strobe_lo = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    wire main_wr   = strobe_lo && cke && cmd.bank[1:0] == 2'h0;
    logic [3:0] rd_cnt;  // cycles left to read data start
    logic [2:0] wr_cnt;  // cycles left to write data start
    //--------------------------------------------------------------
    // latency counters; reads and writes never overlap in the bench
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_cnt <= 4'h0;
            wr_cnt <= 3'h0;
        end else begin
            rd_cnt <= read_cmd ? mode.read_latency : (rd_cnt != 4'h0 ? rd_cnt - 4'h1 : 4'h0);
            wr_cnt <= write_cmd ? mode.write_latency : (wr_cnt != 3'h0 ? wr_cnt - 3'h1 : 3'h0);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_field_decode: assert property (main_wr |=> mode.read_latency == {$past(cmd.addr[2]), $past(cmd.addr[6:4])}
        && mode.write_latency == $past(cmd.addr[11:9]) && mode.test_mode == $past(cmd.addr[7]))
        else $error("mode fields differ from captured address");
    a_burst_decode: assert property (main_wr |=> mode.burst8 == ($past(cmd.addr[1:0]) == BL_CODE_8)
        && mode.sequential == !$past(cmd.addr[3])) else $error("burst fields wrong");
    a_cke_gate: assert property (strobe_lo && !cke |=> $stable({mode.burst8, mode.read_latency}))
        else $error("write taken with clock enable low");
    a_ext_route: assert property (strobe_lo && cke && cmd.bank[0] |=>
        ext_image == $past({cmd.bank, cmd.addr}) && $stable(mode.read_latency)) else $error("extended write misrouted");
    a_dll_start: assert property (main_wr && cmd.addr[8] |=> mode.dll_reset && dll_busy)
        else $error("dll reset not started");
    a_dll_clear: assert property ($rose(mode.dll_reset) |-> ##[1:DLL_LIM] !mode.dll_reset)
        else $error("dll reset bit stuck");
    a_pd_guard: assert property ($rose(dll_busy) |-> (!powerdown_ok)[*8] ##1 (!powerdown_ok)[*2])
        else $error("power-down allowed too early");
    a_read_lat: assert property (rd_cnt == 4'h1 |-> read_data_start) else $error("read data start late");
    a_write_lat: assert property (wr_cnt == 3'h1 |-> write_data_start) else $error("write data start late");
    a_rx_on: assert property ($stable(mode.write_latency) && mode.write_latency inside {[3'h1:WL_RX_MAX]}
        |-> rx_enable) else $error("receivers off at short write latency");
    c_dll: cover property ($rose(dll_busy));
    c_burst8: cover property (mode.burst8 && burst_active);
    c_read: cover property (read_data_start);
endmodule : dmr_mode_reg_chk
bind dmr_mode_reg dmr_mode_reg_chk #(.DLL_CYCLES(DLL_CYCLES)) u_chk (.sys_clk, .reset, .cke, .cmd, .read_cmd,
    .write_cmd, .mode, .ext_image, .read_data_start, .write_data_start, .rx_enable, .burst_active, .dll_busy,
    .powerdown_ok);
`default_nettype wire

// >>> dv/dmr_ctrl_model.sv
// memory controller model driving the command bus
`timescale 1ns/1ns
`default_nettype none
module dmr_ctrl_model
    import dmr_pkg::*;
#(
    parameter int MWI = 4  // mode write interval in cycles
)
(
    input wire logic  sys_clk,
    output logic      cke,
    output var dmr_cmd_s cmd,
    output logic      read_cmd,
    output logic      write_cmd,
    output logic [7:0] col_addr
);
    // deselected with strobes high; released lines toggle, never hold
    initial begin
        cke = 1'b1;
        cmd = '1;
        read_cmd = 1'b0;
        write_cmd = 1'b0;
        col_addr = 8'h00;
    end
    // every task is entered and left at a falling edge
    task set_cke(input logic v);
        cke = v;
        @(negedge sys_clk);
    endtask : set_cke
    // one mode write, then the write interval before anything else
    task mrw(input logic [2:0] b, input logic [11:0] a);
        cmd = {4'h0, a, b};
        @(negedge sys_clk);
        cmd = {4'hF, ~a, ~b};
        repeat (MWI) @(negedge sys_clk);
    endtask : mrw
    // one-cycle column command, column then inverted
    task col_cmd(input logic rd, input logic [7:0] c);
        read_cmd = rd;
        write_cmd = !rd;
        col_addr = c;
        @(negedge sys_clk);
        read_cmd = 1'b0;
        write_cmd = 1'b0;
        col_addr = ~c;
    endtask : col_cmd
    // one no-operation cycle: chip selected, other strobes high
    task nop();
        cmd = {4'h7, 12'h000, 3'h0};
        @(negedge sys_clk);
        cmd = '1;
    endtask : nop
endmodule : dmr_ctrl_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the mode register block
`timescale 1ns/1ns
`default_nettype none
module tb import dmr_pkg::*; ;
    logic sys_clk = 1'b0, reset = 1'b1, refresh_cmd = 1'b0;
    logic cke, read_cmd, write_cmd, read_data_start, write_data_start, rx_enable, burst_active;
    logic calibrate, dll_busy, powerdown_ok, impedance_settled, b8;
    dmr_cmd_s cmd;
    dmr_mode_s mode, em;
    logic [7:0] col_addr, burst_col, c;
    logic [14:0] ext_image;
    logic [11:0] a;
    logic [3:0] rl;
    logic [2:0] wl;
    logic [31:0] seed = 32'h1C, r;
    int cyc = 0, err_count = 0, n_compared = 0;
    int qlat[$];
    logic [7:0] qcol[$];
    dmr_ctrl_model u_dmr_ctrl_model (.sys_clk, .cke, .cmd, .read_cmd, .write_cmd, .col_addr);
    dmr_mode_reg #(.DLL_CYCLES(4)) u_dmr_mode_reg (.sys_clk, .reset, .cke, .cmd, .read_cmd, .write_cmd,
        .refresh_cmd, .col_addr, .mode, .ext_image, .read_data_start, .write_data_start, .rx_enable,
        .burst_col, .burst_active, .calibrate, .dll_busy, .powerdown_ok, .impedance_settled);
    always #50 sys_clk = ~sys_clk;  // period never changes mid-run
    always @(posedge sys_clk) cyc <= cyc + 1;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish();
        $display("mismatches %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // note latency edge and column order, then issue one access
    task op(input logic rd, input int m);
        qlat.push_back(cyc + 1 + m);
        for (int j = 0; j < (b8 ? 8 : 4); j++) qcol.push_back(b8 ? {c[7:3], 3'(c[2:0] + j)} : {c[7:2], 2'(j)});
        u_dmr_ctrl_model.col_cmd(rd, c);
        repeat (16) @(negedge sys_clk);
    endtask : op
    //------------------------------------------------------------------
    // monitor: oldest note is compared whenever a result shows
    //------------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (reset === 1'b0 && (read_data_start === 1'b1 || write_data_start === 1'b1))
            chk(cyc + 1, qlat.size() ? qlat.pop_front() : -1);
        if (reset === 1'b0 && burst_active === 1'b1)
            chk(burst_col, qcol.size() ? qcol.pop_front() : 8'hXX);
    end
    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        chk(powerdown_ok, 1'b1);
        chk(mode, '0);
        chk(impedance_settled, 1'b0);
        // written before any access; legal codes only, sequential type
        for (int i = 0; i < 6; i++) begin
            r = xs();
            rl = 4'h4 + 4'(r[2:0]);
            wl = 3'h1 + r[5:3] % 3'h7;
            b8 = r[6];
            c = {r[14:10], r[7], 2'h0};
            a = {wl, 1'b0, 1'(i == 5), rl[2:0], 1'b0, rl[3], 1'b1, b8};
            u_dmr_ctrl_model.mrw(3'h0, a);
            em = {b8, 1'b1, rl, wl, 1'(i == 5), 1'b0};
            chk(mode, em);
            op(1'b1, rl);
            op(1'b0, wl);
            chk(rx_enable, wl <= 3'h3);
        end
        // strobes low with clock enable low leave the register alone
        u_dmr_ctrl_model.set_cke(1'b0);
        u_dmr_ctrl_model.mrw(3'h0, 12'h000);
        u_dmr_ctrl_model.set_cke(1'b1);
        chk(mode, em);
        u_dmr_ctrl_model.mrw(3'h1, 12'h5A5);
        chk(ext_image, {3'h1, 12'h5A5});
        chk(mode, em);
        u_dmr_ctrl_model.mrw(3'h0, a | 12'h100);
        chk(powerdown_ok, 1'b0);
        repeat (10) @(negedge sys_clk);
        chk({mode.dll_reset, dll_busy, powerdown_ok}, 3'h1);
        // idle nop and refresh each give one calibration pulse
        u_dmr_ctrl_model.nop();
        chk(calibrate, 1'b1);
        refresh_cmd = 1'b1;
        @(negedge sys_clk);
        refresh_cmd = 1'b0;
        chk(calibrate, 1'b1);
        @(negedge sys_clk);
        chk(calibrate, 1'b0);
        chk(impedance_settled, 1'b1);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
